/* inc/sesl_params.svh */
// Constants for the standard event status logic
`ifndef SESL_PARAMS_SVH
`define SESL_PARAMS_SVH
`define SESL_MASK_RESET 8'h00
`define SESL_FLAGS_RESET 8'h00
`define SESL_BIT_OPC 0
`define SESL_BIT_QUERY 2
`define SESL_BIT_DEVDEP 3
`define SESL_BIT_EXEC 4
`define SESL_BIT_CMD 5
`define SESL_STB_ESB 5
`define SESL_USED_BITS 8'h3D
`define SESL_CLASS_CMD 4'h1
`define SESL_CLASS_EXEC 4'h2
`define SESL_CLASS_DEVDEP 4'h3
`define SESL_CLASS_QUERY 4'h4
`define SESL_QUEUE_DEPTH 8
`define SESL_QUEUE_AW 3
`define SESL_CODE_W 10
`endif

/* inc/sesl_pkg.sv */
// Types for the standard event status logic
package sesl_pkg;
   typedef enum logic [1:0] {SESL_OPC_IDLE, SESL_OPC_WAIT} sesl_opc_state_t;
endpackage

/* logic/sesl_event_status.sv */
// Standard event status register, enable mask and error queue
`timescale 1ns/1ps
`include "sesl_params.svh"
// Limits a user should know:
// - the error queue holds eight codes; newer ones are lost until it drains
// - codes outside the four classes are queued but raise no event bit
// - only the summary bit of the status byte is produced here

////////////////////////////////////////////////////////////////////////////////
// Contract
// (RULE1) Clear-status empties error queue, zeroes event registers and status byte, keeps masks.
// (RULE2) Clear-status returns operation-complete tracking to idle, dropping pending request.
// (RULE3) Enable mask takes 0..255, resets to 0; controller stays in range.
// (RULE4) Summary bit 5 is OR of event bits ANDed with mask bits.
// (RULE5) Mask query returns stored mask unchanged.
// (RULE6) Event register query returns contents then clears them.
// (RULE7) Layout: bit0 complete, 2 query, 3 device, 4 execution, 5 command; others unused.
// (RULE8) Error class 1xx sets command error bit.
// (RULE9) Error class 2xx sets execution error bit 4.
// (RULE10) Error class 3xx sets device-dependent error bit 3.
// (RULE11) Output current or voltage error also sets device-dependent error bit.
// (RULE12) Error class 4xx sets query error bit 2.
// (RULE13) Completion bit 0 set only after pending work finishes; commands keep flowing.
// (RULE14) Summary bit follows register and mask changes in the same cycle.
module sesl_event_status
(
   input wire logic sys_clk,
   input wire logic rst_n,
   // Controller commands, one-cycle pulses
   input wire logic clear_status_command,
   input wire logic mask_write,
   input wire logic [7:0] mask_wdata,
   input wire logic mask_query,
   input wire logic flags_query,
   // Error and completion sources
   input wire logic error_raise,
   input wire logic [3:0] error_class,
   input wire logic [`SESL_CODE_W-1:0] error_code,
   input wire logic readback_error,
   input wire logic opc_request,
   input wire logic ops_busy,
   // Queue drain and summary feeders
   input wire logic queue_pop,
   input wire logic oper_event,
   input wire logic ques_event,
   // Query answer, registered
   output logic [7:0] query_data,
   output logic query_valid,
   // Status registers and summaries
   output logic [7:0] event_enable_mask,
   output logic [7:0] standard_event_flags,
   output logic event_summary_bit,
   output logic [7:0] status_byte,
   output logic operation_events,
   output logic questionable_events,
   output logic [`SESL_CODE_W-1:0] queue_head,
   output logic queue_empty,
   output logic opc_pending
);

   logic [7:0] mask_reg;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [7:0] set_bits;
   logic [7:0] query_data_reg;
   logic query_valid_reg;
   logic oper_reg;
   logic ques_reg;
   sesl_pkg::sesl_opc_state_t opc_reg;
   logic opc_done;
   logic cmd_err_hit;
   logic exec_err_hit;
   logic devdep_err_hit;
   logic query_err_hit;
   logic [7:0] flags_keep;

   // Error queue storage and bookkeeping
   logic [`SESL_CODE_W-1:0] queue_mem [`SESL_QUEUE_DEPTH];
   logic [`SESL_QUEUE_AW-1:0] wr_ptr_reg;
   logic [`SESL_QUEUE_AW-1:0] rd_ptr_reg;
   logic [`SESL_QUEUE_AW:0] count_reg;
   logic queue_full;
   logic push;
   logic pop;

   // Reset image of the event flags, one bit per generate copy
   localparam logic [7:0] FLAGS_RESET = `SESL_FLAGS_RESET;

   ////////////////////////////////////////////////////////////////////////////////
   // Enable mask: survives clear-status
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         mask_reg <= `SESL_MASK_RESET; // RULE3
      // Clear-status never reaches this register
      else if (mask_write)
         mask_reg <= mask_wdata; // RULE3 RULE1
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operation-complete tracking
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         opc_reg <= sesl_pkg::SESL_OPC_IDLE;
      else if (clear_status_command)
         opc_reg <= sesl_pkg::SESL_OPC_IDLE; // RULE2
      else
      begin
         case (opc_reg)
            // A request while already waiting is simply absorbed
            sesl_pkg::SESL_OPC_IDLE:
               if (opc_request)
                  opc_reg <= sesl_pkg::SESL_OPC_WAIT;
            // Later commands keep running; only the flag waits
            sesl_pkg::SESL_OPC_WAIT:
               if (!ops_busy)
                  opc_reg <= sesl_pkg::SESL_OPC_IDLE; // RULE13
            default:
               opc_reg <= sesl_pkg::SESL_OPC_IDLE;
         endcase
      end
   end

   // Done fires in the cycle the busy level drops, so bit 0 lands one edge later
   assign opc_done = (opc_reg == sesl_pkg::SESL_OPC_WAIT) && !ops_busy; // RULE13
   assign opc_pending = (opc_reg == sesl_pkg::SESL_OPC_WAIT);

   ////////////////////////////////////////////////////////////////////////////////
   // Error class decode; the hundreds digit picks the event bit
   assign cmd_err_hit = error_raise && (error_class == `SESL_CLASS_CMD); // RULE8
   assign exec_err_hit = error_raise && (error_class == `SESL_CLASS_EXEC); // RULE9
   assign devdep_err_hit = (error_raise && (error_class == `SESL_CLASS_DEVDEP))
      || readback_error; // RULE10 RULE11
   assign query_err_hit = error_raise && (error_class == `SESL_CLASS_QUERY); // RULE12

   ////////////////////////////////////////////////////////////////////////////////
   // Event sources; a new event beats a read clear in the same cycle
   always_comb
   begin
      set_bits = 8'h00;
      set_bits[`SESL_BIT_OPC] = opc_done; // RULE13
      set_bits[`SESL_BIT_CMD] = cmd_err_hit; // RULE8
      set_bits[`SESL_BIT_EXEC] = exec_err_hit; // RULE9
      set_bits[`SESL_BIT_DEVDEP] = devdep_err_hit; // RULE10 RULE11
      set_bits[`SESL_BIT_QUERY] = query_err_hit; // RULE12
   end

   // A flag query hands the old contents out and drops them
   assign flags_keep = flags_query ? 8'h00 : flags_reg; // RULE6

   // Clear-status overrides every source, events of that cycle included
   always_comb
   begin
      if (clear_status_command)
         flags_next = 8'h00; // RULE1
      else
         flags_next = (flags_keep | set_bits) & `SESL_USED_BITS; // RULE7
   end

   // One flop per event bit
   generate
      for (genvar b = 0; b < 8; b++)
      begin : g_flag
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               flags_reg[b] <= FLAGS_RESET[b];
            else
               flags_reg[b] <= flags_next[b];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Operation and questionable summaries, sticky until clear-status
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         oper_reg <= 1'b0;
      else if (clear_status_command)
         oper_reg <= 1'b0; // RULE1
      else if (oper_event)
         oper_reg <= 1'b1;
   end

   // Readback errors are questionable conditions as well
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ques_reg <= 1'b0;
      else if (clear_status_command)
         ques_reg <= 1'b0; // RULE1
      else if (ques_event || readback_error)
         ques_reg <= 1'b1; // RULE11
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Query answers; flag query wins if both asked at once
   // One-cycle strobe, never held
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         query_valid_reg <= 1'b0;
      else
         query_valid_reg <= flags_query | mask_query;
   end

   // Data holds until the next query
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         query_data_reg <= 8'h00;
      else if (flags_query)
         query_data_reg <= flags_reg; // RULE6
      else if (mask_query)
         query_data_reg <= mask_reg; // RULE5
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Error queue; a full queue drops new codes, the event bit still sets
   assign queue_full = (count_reg == (`SESL_QUEUE_AW+1)'(`SESL_QUEUE_DEPTH));
   assign push = error_raise && !queue_full;
   assign pop = queue_pop && !queue_empty;

   // Storage needs no reset; the count says what is valid
   always_ff @(posedge sys_clk)
   begin
      if (push)
         queue_mem[wr_ptr_reg] <= error_code;
   end

   // Write side
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         wr_ptr_reg <= '0;
      else if (clear_status_command)
         wr_ptr_reg <= '0; // RULE1
      else if (push)
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
   end

   // Read side
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_ptr_reg <= '0;
      else if (clear_status_command)
         rd_ptr_reg <= '0; // RULE1
      else if (pop)
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
   end

   // Push and pop together leave the count alone
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         count_reg <= '0;
      else if (clear_status_command)
         count_reg <= '0; // RULE1
      else if (push && !pop)
         count_reg <= count_reg + 1'b1;
      else if (pop && !push)
         count_reg <= count_reg - 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Combinational so the summary moves in the cycle the registers do
   assign event_summary_bit = |(flags_reg & mask_reg); // RULE4 RULE14

   // Other status byte sources live outside this block
   generate
      for (genvar s = 0; s < 8; s++)
      begin : g_status
         if (s == `SESL_STB_ESB)
         begin : g_esb
            assign status_byte[s] = event_summary_bit; // RULE4
         end
         else
         begin : g_zero
            assign status_byte[s] = 1'b0;
         end
      end
   endgenerate

   assign event_enable_mask = mask_reg;
   assign standard_event_flags = flags_reg;
   assign query_data = query_data_reg;
   assign query_valid = query_valid_reg;
   assign operation_events = oper_reg;
   assign questionable_events = ques_reg;
   assign queue_empty = (count_reg == '0);
   // Head reads as zero when empty so stale codes never show
   assign queue_head = queue_empty ? '0 : queue_mem[rd_ptr_reg];

endmodule

/* tb/sesl_ctrl_model.sv */
// Controller model that sends status commands as one-cycle pulses
`timescale 1ns/1ps
module sesl_ctrl_model
(
   input logic sys_clk,
   output logic clear_status_command,
   output logic mask_write,
   output logic [7:0] mask_wdata,
   output logic mask_query,
   output logic flags_query,
   output logic error_raise,
   output logic [3:0] error_class,
   output logic [9:0] error_code,
   output logic readback_error,
   output logic opc_request,
   output logic ops_busy,
   output logic queue_pop,
   output logic oper_event,
   output logic ques_event
);
   logic [9:0] pulse = 10'h000;
   assign {ques_event, oper_event, queue_pop, clear_status_command, opc_request,
      readback_error, error_raise, flags_query, mask_query, mask_write} = pulse;
   initial {mask_wdata, error_class, error_code, ops_busy} = 23'h000000;
   task automatic send(input logic [9:0] p, input logic [7:0] arg);
      @(posedge sys_clk);
      #1;
      pulse = p;
      {mask_wdata, error_class, error_code} = {arg, arg[3:0], arg, 2'h1};
      @(posedge sys_clk);
      #1;
      pulse = 10'h000;
      // Scramble released fields so a late sample cannot match
      {mask_wdata, error_class} = ~{arg, arg[3:0]};
   endtask
   task automatic busy(input logic b);
      ops_busy = b;
   endtask
endmodule

/* tb/sesl_monitor.sv */
// Assertion checker bound to the event status block
`timescale 1ns/1ps
module sesl_monitor
(
   input logic sys_clk,
   input logic rst_n,
   input logic clear_status_command,
   input logic mask_write,
   input logic [7:0] mask_wdata,
   input logic mask_query,
   input logic flags_query,
   input logic error_raise,
   input logic readback_error,
   input logic [3:0] error_class,
   input logic ops_busy,
   input logic [7:0] query_data,
   input logic query_valid,
   input logic [7:0] event_enable_mask,
   input logic [7:0] standard_event_flags,
   input logic [7:0] status_byte,
   input logic opc_pending
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   summary_or_a: assert property (
      status_byte == {2'h0, |(standard_event_flags & event_enable_mask), 5'h00}) else $error("summary");
   unused_zero_a: assert property ((standard_event_flags & 8'hC2) == 8'h00)
      else $error("unused bit set");
   clear_all_a: assert property (clear_status_command |=> !opc_pending &&
      standard_event_flags == 8'h00) else $error("clear missed");
   mask_store_a: assert property (mask_write |=> event_enable_mask == $past(mask_wdata))
      else $error("mask not stored");
   mask_read_a: assert property (
      mask_query && !flags_query && !mask_write && !clear_status_command |=> query_valid &&
      query_data == $past(event_enable_mask) && $stable(event_enable_mask)) else $error("mask read");
   flags_read_a: assert property (flags_query && !clear_status_command |=> query_valid &&
      query_data == $past(standard_event_flags)) else $error("flags read");
   error_class_a: assert property (
      error_raise && error_class inside {[4'h1:4'h4]} && !clear_status_command |=>
      standard_event_flags[3'd6 - $past(error_class[2:0])]) else $error("error class");
   opc_done_a: assert property (opc_pending && !ops_busy && !clear_status_command |=>
      standard_event_flags[0] && !opc_pending) else $error("completion");
   readback_flag_a: assert property (readback_error && !clear_status_command |=>
      standard_event_flags[3]) else $error("readback error flag");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sesl_event_status sesl_monitor u_mon (.*);

/* tb/tb_top.sv */
// Self-checking testbench for the event status block
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clear_status_command, mask_write, mask_query, flags_query, error_raise, readback_error;
   logic opc_request, ops_busy, query_valid, event_summary_bit, queue_empty, opc_pending;
   logic queue_pop, oper_event, ques_event, operation_events, questionable_events;
   logic [3:0] error_class;
   logic [9:0] error_code, queue_head;
   logic [7:0] mask_wdata, query_data, event_enable_mask, standard_event_flags, status_byte;
   int mismatches = 0;
   int tests_run = 0;
   always #4 sys_clk = ~sys_clk;
   sesl_ctrl_model u_ctrl (.*);
   sesl_event_status u_dut (.*);
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      mismatches += int'(got !== exp);
      if (got !== exp)
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
   endtask
   task automatic q(input logic [6:0] p, input logic [7:0] arg, input logic [7:0] exp);
      u_ctrl.send(p, arg);
      check(query_valid, 1'b1);
      check(query_data, exp);
   endtask
   task automatic results;
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      q(7'h02, 8'h00, 8'h00);
      q(7'h04, 8'h00, 8'h00);
      u_ctrl.send(7'h01, 8'h3C);
      q(7'h02, 8'h00, 8'h3C);
      q(7'h02, 8'h00, 8'h3C);
      for (int i = 0; i < 4; i++)
      begin
         u_ctrl.send(7'h08, 8'(i + 1));
         check(status_byte, 8'h20);
         q(7'h04, 8'h00, 8'(8'h40 >> (i + 1)));
         check(event_summary_bit, 1'b0);
      end
      u_ctrl.send(7'h10, 8'h00);
      q(7'h04, 8'h00, 8'h08);
      u_ctrl.send(7'h01, 8'h04);
      u_ctrl.send(7'h08, 8'h01);
      check(event_summary_bit, 1'b0);
      u_ctrl.send(7'h01, 8'h20);
      check(event_summary_bit, 1'b1);
      // Event in the query cycle survives the read clear
      q(7'h0C, 8'h02, 8'h20);
      check(standard_event_flags, 8'h10);
      u_ctrl.send(10'h100, 8'h00);
      check({operation_events, questionable_events}, 2'b11);
      check(queue_head, 10'h005);
      u_ctrl.send(10'h080, 8'h00);
      check(queue_head, 10'h009);
      u_ctrl.busy(1'b1);
      u_ctrl.send(7'h20, 8'h00);
      check(opc_pending, 1'b1);
      u_ctrl.send(7'h40, 8'h00);
      check({standard_event_flags, queue_empty, opc_pending}, {8'h00, 2'b10});
      check(status_byte, 8'h00);
      check(event_enable_mask, 8'h20);
      check({operation_events, questionable_events}, 2'b00);
      check(queue_head, 10'h000);
      u_ctrl.send(7'h20, 8'h00);
      repeat (3) @(posedge sys_clk);
      #1;
      check(standard_event_flags, 8'h00);
      u_ctrl.busy(1'b0);
      @(posedge sys_clk);
      #1;
      check({standard_event_flags, opc_pending}, {8'h01, 1'b0});
      results();
   end
endmodule
